// ### smie_exec.sv
// Execution unit for right shift, file copy, indirect load and bank literal.
// Assumes data memory answers o_mem_rd one clock later on i_mem_rdata,
// and that the decoder only presents instructions while o_busy is low.
//
// Notes on behaviour
// - Right shift moves operand bits 7:1 down one and clears bit 7.
// - Right shift puts operand bit 0 in carry and updates zero.
// - Destination 0 writes the accumulator, 1 writes the file register.
// - Copy of a non-alias register moves it to destination in one cycle, zero only.
// - Copy onto itself leaves the value but still updates zero.
// - Indirect load reads via selected pointer into accumulator, updates zero.
// - Mode 00/01/10/11: pre-inc, pre-dec, post-inc, post-dec of pointer.
// - Relative access uses pointer plus signed -32..31; pointer unchanged.
// - Alias file slots are reached only from the register bus; instruction access goes through the pointer.
// - Pointers are 16 bits and wrap at both ends.
// - Bank literal 0..15 loads the bank latch; flags untouched.
module smie_exec
   import smie_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_srst,
   input  wire logic              i_instr_valid,
   input  wire smie_instr_s       i_instr,
   input  wire logic [7:0]        i_mem_rdata,
   input  wire logic [9:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   output logic      [15:0]       o_mem_addr,
   output logic                   o_mem_rd,
   output logic                   o_mem_wr,
   output logic      [7:0]        o_mem_wdata,
   output logic      [7:0]        o_w,
   output logic                   o_carry,
   output logic                   o_zero,
   output logic      [4:0]        o_bank,
   output logic                   o_busy,
   output logic                   o_done
);
   function automatic logic is_alias(input logic [6:0] fa);
      return (fa == ALIAS0_ADDR) || (fa == ALIAS1_ADDR);
   endfunction

   function automatic logic bus_hit(input logic [9:0] a, input logic [9:0] off);
      return a == off;
   endfunction

   smie_state_e state;
   smie_state_e next_state;
   smie_instr_s held;
   smie_instr_s cur;
   logic [7:0]  file_mem [FILE_DEPTH];
   logic [15:0] ptr [2];
   logic [15:0] step_eff;
   logic [15:0] step_next;
   logic [15:0] mem_addr_sel;
   logic [7:0]  opnd;
   logic [7:0]  result;
   logic [31:0] rd_mux;
   logic        st_idle;
   logic        st_data;
   logic        cur_alias;
   logic        issue;
   logic        needs_mem;
   logic        issue_mem;
   logic        exec_fire;
   logic        is_lsr;
   logic        is_copy;
   logic        wr_w;
   logic        wr_file;
   logic        wr_mem;
   logic        upd_zero;
   logic        upd_carry;
   logic        wr_bank;
   logic        ptr_upd;
   logic        file_hit;
   logic        bw_w;
   logic        bw_status;
   logic        bw_bank;
   logic        bw_file;

   // ---------------- Decode ----------------
   assign st_idle   = (state == ST_IDLE);
   assign st_data   = (state == ST_DATA);
   assign cur       = st_idle ? i_instr : held;
   assign is_lsr    = (cur.op == OP_LSR);
   assign is_copy   = (cur.op == OP_COPY);
   assign cur_alias = (is_lsr || is_copy) && is_alias(cur.faddr);
   assign issue     = st_idle && i_instr_valid;
   assign needs_mem = (cur.op == OP_LOAD) || cur_alias;
   assign issue_mem = issue && needs_mem;
   // Direct ops finish in the issue cycle; memory ops finish when data returns
   assign exec_fire = (issue && !needs_mem) || st_data;

   // ---------------- Datapath ----------------
   assign opnd   = st_data ? i_mem_rdata : file_mem[cur.faddr];
   assign result = is_lsr ? {1'b0, opnd[7:1]} : opnd;

   assign wr_w      = exec_fire && ((cur.op == OP_LOAD) || ((is_lsr || is_copy) && !cur.dest));
   // Copy back onto itself is skipped: same value, and it saves a write
   assign wr_file   = exec_fire && is_lsr && cur.dest && !cur_alias;
   assign wr_mem    = exec_fire && is_lsr && cur.dest && cur_alias;
   assign upd_zero  = exec_fire && (cur.op != OP_BANK);
   assign upd_carry = exec_fire && is_lsr;
   assign wr_bank   = exec_fire && (cur.op == OP_BANK);
   assign ptr_upd   = issue && (cur.op == OP_LOAD) && !cur.rel;

   smie_ptr_step u_step (
      .i_ptr    (ptr[cur.psel]),
      .i_mode   (cur.pmode),
      .i_rel    (cur.rel),
      .i_offset (cur.offset),
      .o_eff    (step_eff),
      .o_next   (step_next)
   );

   assign mem_addr_sel = (cur.op == OP_LOAD) ? step_eff : ptr[cur.faddr[0]];

   // ---------------- Register bus decode ----------------
   assign file_hit  = (i_addr[9] == OFF_FILE[9]);
   assign bw_w      = i_wr && bus_hit(i_addr, OFF_W);
   assign bw_status = i_wr && bus_hit(i_addr, OFF_STATUS);
   assign bw_bank   = i_wr && bus_hit(i_addr, OFF_BANK);
   assign bw_file   = i_wr && file_hit;

   assign rd_mux = file_hit                      ? {24'h000000, file_mem[i_addr[8:2]]} :
                   bus_hit(i_addr, OFF_W)        ? {24'h000000, o_w} :
                   bus_hit(i_addr, OFF_STATUS)   ? {30'h00000000, o_zero, o_carry} :
                   bus_hit(i_addr, OFF_BANK)     ? {27'h0000000, o_bank} :
                   bus_hit(i_addr, OFF_PTR0)     ? {16'h0000, ptr[0]} :
                   bus_hit(i_addr, OFF_PTR1)     ? {16'h0000, ptr[1]} :
                   bus_hit(i_addr, OFF_STATE)    ? {31'h00000000, o_busy} :
                   32'h00000000;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rdata <= 32'h00000000;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h00000000;
      end
   end

   // ---------------- Sequencer ----------------
   always_comb begin
      case (state)
         ST_IDLE: next_state = issue_mem ? ST_READ : ST_IDLE;
         ST_READ: next_state = ST_DATA;
         ST_DATA: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state  <= ST_IDLE;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         state  <= next_state;
         o_busy <= (next_state != ST_IDLE);
         o_done <= exec_fire;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         held <= '0;
      end else if (issue_mem) begin
         held <= i_instr;
      end
   end

   // ---------------- Memory port ----------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_mem_addr  <= RST_PTR;
         o_mem_rd    <= 1'b0;
         o_mem_wr    <= 1'b0;
         o_mem_wdata <= 8'h00;
      end else begin
         o_mem_rd <= issue_mem;
         o_mem_wr <= wr_mem;
         if (issue_mem) begin
            o_mem_addr <= mem_addr_sel;
         end
         if (wr_mem) begin
            o_mem_wdata <= result;
         end
      end
   end

   // ---------------- Pointers ----------------
   // Execution wins over a bus write to the same pointer in the same cycle
   for (genvar gi = 0; gi < 2; gi++) begin : g_ptr
      localparam logic [9:0] PTR_OFF = (gi == 0) ? OFF_PTR0 : OFF_PTR1;
      always_ff @(posedge i_clk) begin
         if (i_srst) begin
            ptr[gi] <= RST_PTR;
         end else if (ptr_upd && (cur.psel == 1'(gi))) begin
            ptr[gi] <= step_next;
         end else if (i_wr && bus_hit(i_addr, PTR_OFF)) begin
            ptr[gi] <= i_wdata[15:0];
         end
      end
   end

   // ---------------- Accumulator, flags, bank ----------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_w <= RST_W;
      end else if (wr_w) begin
         o_w <= result;
      end else if (bw_w) begin
         o_w <= i_wdata[7:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_carry <= RST_FLAG;
         o_zero  <= RST_FLAG;
      end else begin
         if (upd_carry) begin
            o_carry <= opnd[0];
         end else if (bw_status) begin
            o_carry <= i_wdata[STAT_C_BIT];
         end
         if (upd_zero) begin
            o_zero <= (result == 8'h00);
         end else if (bw_status) begin
            o_zero <= i_wdata[STAT_Z_BIT];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_bank <= RST_BANK;
      end else if (wr_bank) begin
         o_bank <= {1'b0, cur.lit};
      end else if (bw_bank) begin
         o_bank <= i_wdata[4:0];
      end
   end

   // File array holds data, not control state, so it has no reset
   always_ff @(posedge i_clk) begin
      if (wr_file) begin
         file_mem[cur.faddr] <= result;
      end else if (bw_file) begin
         file_mem[i_addr[8:2]] <= i_wdata[7:0];
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   chk_shift_msb_zero: assert property (
      (exec_fire && is_lsr && !cur.dest) |=> (o_w == {1'b0, $past(opnd[7:1])}))
      else $error("shift result not operand shifted right with zero msb");

   chk_shift_carry: assert property (
      (exec_fire && is_lsr) |=> (o_carry == $past(opnd[0])))
      else $error("carry not loaded from operand bit 0");

   chk_dest_file_keeps_w: assert property (
      (exec_fire && (is_lsr || is_copy) && cur.dest && !bw_w) |=> $stable(o_w))
      else $error("accumulator changed for file destination");

   chk_copy_one_cycle: assert property (
      (issue && is_copy && !cur_alias) |=> (o_done && !o_busy && $stable(o_carry)))
      else $error("direct copy did not finish in one cycle");

   chk_copy_self_nowrite: assert property (
      (exec_fire && is_copy && cur.dest && !bw_file)
      |=> (($past(cur_alias) || (file_mem[$past(cur.faddr)] == $past(opnd))) && !o_mem_wr
           && (o_zero == ($past(opnd) == 8'h00))))
      else $error("copy onto itself changed the register or skipped zero");

   chk_load_value: assert property (
      (st_data && (cur.op == OP_LOAD))
      |=> ((o_w == $past(i_mem_rdata)) && (o_zero == ($past(i_mem_rdata) == 8'h00))))
      else $error("indirect load value or zero flag wrong");

   chk_preinc_addr: assert property (
      (issue && (cur.op == OP_LOAD) && !cur.rel && (cur.pmode == MODE_PREINC) && !cur.psel)
      |=> ((ptr[0] == 16'($past(ptr[0]) + 16'h0001)) && (o_mem_addr == ptr[0]) ##1 st_data))
      else $error("pre-increment address or pointer wrong");

   chk_rel_addr: assert property (
      (issue && (cur.op == OP_LOAD) && cur.rel && !cur.psel)
      |=> ($stable(ptr[0]) && (o_mem_addr == 16'($past(ptr[0]) + {{10{$past(cur.offset[5])}}, $past(cur.offset)}))))
      else $error("relative address or pointer wrong");

   chk_alias_addr: assert property (
      (issue && cur_alias) |=> (o_mem_rd && (o_mem_addr == $past(ptr[cur.faddr[0]]))))
      else $error("alias access not routed through pointer");

   chk_ptr_wrap: assert property (
      (ptr_upd && cur.psel && (cur.pmode == MODE_POSTDEC) && (ptr[1] == 16'h0000)) |=> (ptr[1] == 16'hFFFF))
      else $error("pointer did not wrap below zero");

   chk_bank_flags: assert property (
      (exec_fire && (cur.op == OP_BANK))
      |=> ((o_bank == {1'b0, $past(cur.lit)}) && $stable(o_carry) && $stable(o_zero)))
      else $error("bank literal wrong or flags touched");

   chk_copy_value: assert property (
      (exec_fire && is_copy && !cur.dest) |=> (o_w == $past(opnd)))
      else $error("copy did not move the operand to the accumulator");

   chk_zero_from_w: assert property (
      wr_w |=> (o_zero == (o_w == 8'h00)))
      else $error("zero flag does not match accumulator result");

   chk_alias_write: assert property (
      (exec_fire && cur_alias && is_lsr && cur.dest)
      |=> (o_mem_wr && (o_mem_wdata == {1'b0, $past(i_mem_rdata[7:1])})))
      else $error("alias shift result not written through pointer");

   chk_predec_addr: assert property (
      (issue && (cur.op == OP_LOAD) && !cur.rel && (cur.pmode == MODE_PREDEC) && !cur.psel)
      |=> ((ptr[0] == 16'($past(ptr[0]) - 16'h0001)) && (o_mem_addr == ptr[0])))
      else $error("pre-decrement address or pointer wrong");

   chk_post_addr: assert property (
      (issue && (cur.op == OP_LOAD) && !cur.rel && cur.psel
       && ((cur.pmode == MODE_POSTINC) || (cur.pmode == MODE_POSTDEC)))
      |=> (o_mem_addr == $past(ptr[1])))
      else $error("post-update access did not use the old pointer");

   // Memory data is taken only in the cycle after the request
   chk_mem_read_pulse: assert property (
      issue_mem |=> (o_mem_rd && o_busy) ##1 (!o_mem_rd && o_busy) ##1 (o_done && !o_busy))
      else $error("memory read sequence out of step");

   cov_alias_shift_write: cover property (issue && cur_alias && is_lsr && cur.dest ##3 o_mem_wr);
   cov_load_postdec: cover property (ptr_upd && (cur.pmode == MODE_POSTDEC) ##3 o_done);
   cov_copy_zero: cover property (issue && is_copy ##1 o_zero);
   cov_bank_load: cover property (issue && (cur.op == OP_BANK));
   cov_rel_load: cover property (issue && (cur.op == OP_LOAD) && cur.rel ##3 o_done);
endmodule

// ### smie_pkg.sv
// Shared constants and types for the shift/move/indirect execution block.
// Assumes one core clock; data memory answers a read one clock later.
package smie_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned PTR_W      = 16;
   localparam int unsigned FILE_DEPTH = 128;
   localparam int unsigned BUS_AW     = 10;
   localparam int unsigned BANK_W     = 5;

   // Register bus offsets (byte addresses)
   localparam logic [9:0] OFF_W      = 10'h000;
   localparam logic [9:0] OFF_STATUS = 10'h004;
   localparam logic [9:0] OFF_BANK   = 10'h008;
   localparam logic [9:0] OFF_PTR0   = 10'h00C;
   localparam logic [9:0] OFF_PTR1   = 10'h010;
   localparam logic [9:0] OFF_STATE  = 10'h014;
   localparam logic [9:0] OFF_FILE   = 10'h200;

   localparam int unsigned STAT_C_BIT = 0;
   localparam int unsigned STAT_Z_BIT = 1;
   localparam int unsigned STATE_BUSY_BIT = 0;

   localparam logic [7:0]  RST_W     = 8'h00;
   localparam logic        RST_FLAG  = 1'b0;
   localparam logic [4:0]  RST_BANK  = 5'h00;
   localparam logic [15:0] RST_PTR   = 16'h0000;

   localparam logic [6:0] ALIAS0_ADDR = 7'h00;
   localparam logic [6:0] ALIAS1_ADDR = 7'h01;

   localparam logic [1:0] MODE_PREINC  = 2'b00;
   localparam logic [1:0] MODE_PREDEC  = 2'b01;
   localparam logic [1:0] MODE_POSTINC = 2'b10;
   localparam logic [1:0] MODE_POSTDEC = 2'b11;

   typedef enum logic [1:0] {
      OP_LSR  = 2'h0,
      OP_COPY = 2'h1,
      OP_LOAD = 2'h2,
      OP_BANK = 2'h3
   } smie_op_e;

   typedef struct packed {
      smie_op_e    op;
      logic        dest;
      logic [6:0]  faddr;
      logic        psel;
      logic [1:0]  pmode;
      logic        rel;
      logic [5:0]  offset;
      logic [3:0]  lit;
   } smie_instr_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_DATA = 3'b100
   } smie_state_e;
endpackage

// ### smie_ptr_step.sv
// Pointer step: effective address and next pointer value for one access.
// Purely combinational; the caller decides when to store the result.
module smie_ptr_step
   import smie_pkg::*;
(
   input  wire logic [15:0] i_ptr,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_rel,
   input  wire logic [5:0]  i_offset,
   output logic      [15:0] o_eff,
   output logic      [15:0] o_next
);
   logic [15:0] ptr_inc;
   logic [15:0] ptr_dec;
   logic [15:0] ptr_rel;
   logic        mode_pre;
   logic        mode_inc;

   // 16-bit arithmetic wraps at both ends by itself
   assign ptr_inc  = 16'(i_ptr + 16'h0001);
   assign ptr_dec  = 16'(i_ptr - 16'h0001);
   assign ptr_rel  = 16'(i_ptr + {{10{i_offset[5]}}, i_offset});
   assign mode_pre = (i_mode == MODE_PREINC) || (i_mode == MODE_PREDEC);
   assign mode_inc = (i_mode == MODE_PREINC) || (i_mode == MODE_POSTINC);
   assign o_next   = i_rel ? i_ptr : (mode_inc ? ptr_inc : ptr_dec);
   assign o_eff    = i_rel ? ptr_rel : (mode_pre ? o_next : i_ptr);
endmodule

// ### tb_shift_move_indirect_exec.sv
// Self-checking bench for smie_exec: direct ops from a row table, then indirect loads, aliases and reset.
// Assumes one 250 MHz core clock; memory read data is driven only in the cycle after the read request.
module tb_shift_move_indirect_exec
   import smie_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [1:0] op;
      logic       d;
      logic [6:0] f;
      logic [7:0] v;
      logic [7:0] res;
      logic       c;
      logic       z;
   } smie_row_s;

   typedef struct packed {
      logic        s;
      logic [1:0]  m;
      logic        rel;
      logic [5:0]  off;
      logic [15:0] p;
      logic [7:0]  dat;
      logic [15:0] ea;
      logic [15:0] np;
   } smie_mrow_s;

   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_instr_valid = 1'b0;
   smie_instr_s i_instr = '0;
   logic [7:0]  i_mem_rdata = 8'h00;
   logic [9:0]  i_addr = 10'h000;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic [15:0] o_mem_addr;
   logic        o_mem_rd, o_mem_wr, o_carry, o_zero, o_busy, o_done;
   logic [7:0]  o_mem_wdata, o_w;
   logic [4:0]  o_bank;
   int          err_count = 0;
   int          checks_done = 0;
   logic [15:0] mem_a;
   logic        mem_seen, mem_wr_s;
   logic [7:0]  mem_wd;
   smie_instr_s ins;

   // Direct ops in order; flags carry over, so a bank row proves flags are left alone
   smie_row_s rows [8] = '{
      '{2'h0, 1'b0, 7'h05, 8'h81, 8'h40, 1'b1, 1'b0},
      '{2'h0, 1'b1, 7'h06, 8'h01, 8'h00, 1'b1, 1'b1},
      '{2'h3, 1'b0, 7'h0A, 8'h0F, 8'h0F, 1'b1, 1'b1},
      '{2'h1, 1'b0, 7'h08, 8'h00, 8'h00, 1'b1, 1'b1},
      '{2'h0, 1'b0, 7'h07, 8'hFE, 8'h7F, 1'b0, 1'b0},
      '{2'h1, 1'b1, 7'h09, 8'h5A, 8'h5A, 1'b0, 1'b0},
      '{2'h3, 1'b0, 7'h0A, 8'h00, 8'h00, 1'b0, 1'b0},
      '{2'h0, 1'b1, 7'h7F, 8'h00, 8'h00, 1'b0, 1'b1}};

   smie_mrow_s mrows [6] = '{
      '{1'b0, 2'b00, 1'b0, 6'h00, 16'hFFFF, 8'h00, 16'h0000, 16'h0000},
      '{1'b0, 2'b01, 1'b0, 6'h00, 16'h0000, 8'h37, 16'hFFFF, 16'hFFFF},
      '{1'b1, 2'b10, 1'b0, 6'h00, 16'h1234, 8'h80, 16'h1234, 16'h1235},
      '{1'b1, 2'b11, 1'b0, 6'h00, 16'h0000, 8'h00, 16'h0000, 16'hFFFF},
      '{1'b1, 2'b00, 1'b1, 6'h20, 16'h1234, 8'h01, 16'h1214, 16'h1234},
      '{1'b0, 2'b11, 1'b1, 6'h1F, 16'hFFF0, 8'hC3, 16'h000F, 16'hFFF0}};

   smie_exec dut_u (
      .i_clk(i_clk), .i_srst(i_srst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_mem_rdata(i_mem_rdata), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
      .o_mem_wdata(o_mem_wdata), .o_w(o_w), .o_carry(o_carry), .o_zero(o_zero), .o_bank(o_bank),
      .o_busy(o_busy), .o_done(o_done));

   initial begin
      forever #2 i_clk = ~i_clk;
   end

   task automatic give_verdict();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rst_state();
      chk({o_w, o_carry, o_zero, o_bank, o_busy, o_done, o_mem_rd, o_mem_wr}, 32'h0);
      chk({o_mem_addr, o_mem_wdata}, 32'h0);
      chk(o_rdata, 32'h0);
   endtask

   task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic bus_rd(input logic [9:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   // Issues one instruction and waits for done; memory data stands only in the cycle after the request,
   // so a design that takes it a cycle early or late reads the inverted value
   task automatic exec(input smie_instr_s in, input logic [7:0] md, input int lat);
      int   n;
      logic data_now;
      @(posedge i_clk);
      i_instr       <= in;
      i_mem_rdata   <= ~md;
      i_instr_valid <= 1'b1;
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      #1;
      n = 1;
      mem_seen = 1'b0;
      chk(o_busy, lat > 1);
      while (o_done !== 1'b1 && n < 8) begin
         data_now = (o_mem_rd === 1'b1);
         if (data_now) begin
            mem_seen = 1'b1;
            mem_a = o_mem_addr;
         end
         @(posedge i_clk);
         i_mem_rdata <= data_now ? md : ~md;
         #1;
         n++;
      end
      if (n >= 8) begin
         err_count++;
         $display("ERROR at %0t: no done", $time);
         give_verdict();
      end
      mem_wr_s = o_mem_wr;
      mem_wd   = o_mem_wdata;
      chk(n, lat);
   endtask

   initial begin
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      #1;
      chk_rst_state();
      bus_rd(OFF_PTR0, 32'h0);
      foreach (rows[i]) begin
         bus_wr(OFF_FILE | {1'b0, rows[i].f, 2'b00}, {24'h0, rows[i].v});
         ins = '0;
         ins.op = smie_op_e'(rows[i].op);
         ins.dest = rows[i].d;
         ins.faddr = rows[i].f;
         ins.lit = rows[i].v[3:0];
         exec(ins, 8'hA5, 1);
         chk(mem_seen, 1'b0);
         if (rows[i].op == 2'h3) begin
            chk(o_bank, rows[i].res);
         end else if (rows[i].d) begin
            bus_rd(OFF_FILE | {1'b0, rows[i].f, 2'b00}, rows[i].res);
         end else begin
            chk(o_w, rows[i].res);
         end
         chk(o_carry, rows[i].c);
         chk(o_zero, rows[i].z);
      end
      foreach (mrows[i]) begin
         bus_wr(mrows[i].s ? OFF_PTR1 : OFF_PTR0, {16'h0, mrows[i].p});
         ins = '0;
         ins.op = OP_LOAD;
         ins.psel = mrows[i].s;
         ins.pmode = mrows[i].m;
         ins.rel = mrows[i].rel;
         ins.offset = mrows[i].off;
         exec(ins, mrows[i].dat, 3);
         chk({mem_a, mem_wr_s}, {mrows[i].ea, 1'b0});
         chk(o_w, mrows[i].dat);
         chk(o_zero, mrows[i].dat == 8'h00);
         bus_rd(mrows[i].s ? OFF_PTR1 : OFF_PTR0, {16'h0, mrows[i].np});
      end
      // Alias shift writes back through pointer 1, never to its own file slot
      bus_wr(OFF_PTR1, 32'h0042);
      ins = '0;
      ins.op = OP_LSR;
      ins.dest = 1'b1;
      ins.faddr = ALIAS1_ADDR;
      exec(ins, 8'h03, 3);
      chk({mem_a, mem_wr_s, mem_wd}, {16'h0042, 1'b1, 8'h01});
      chk({o_carry, o_zero, o_w}, {2'b10, 8'hC3});
      bus_wr(OFF_PTR0, 32'h0100);
      ins.op = OP_COPY;
      ins.dest = 1'b0;
      ins.faddr = ALIAS0_ADDR;
      exec(ins, 8'h9C, 3);
      chk({mem_a, o_w, o_zero, mem_wr_s}, {16'h0100, 8'h9C, 1'b0, 1'b0});
      bus_rd(10'h018, 32'h0);
      bus_wr(OFF_STATE, 32'hFFFF_FFFF);
      bus_rd(OFF_STATE, 32'h0);
      // Load accumulator, flags and bank with non-zero values first, so the reset check means something
      bus_wr(OFF_W, 32'h0000_01A5);
      bus_rd(OFF_W, 32'h0000_00A5);
      bus_wr(OFF_STATUS, 32'h0000_0003);
      bus_rd(OFF_STATUS, 32'h0000_0003);
      bus_wr(OFF_BANK, 32'h0000_003F);
      bus_rd(OFF_BANK, 32'h0000_001F);
      // Reset in mid-run clears accumulator, flags, bank, memory port and pointers
      @(posedge i_clk);
      i_srst <= 1'b1;
      @(posedge i_clk);
      i_srst <= 1'b0;
      #1;
      chk_rst_state();
      bus_rd(OFF_PTR1, 32'h0);
      bus_rd(OFF_PTR0, 32'h0);
      give_verdict();
   end
endmodule
